// ===== rtl/aas_pkg.sv
// shared constants for the alert aggregation and signalling block
package aas_pkg;

   // link topology selection
   localparam logic [1:0] TOPO_EXT_LOOP  = 2'h0;
   localparam logic [1:0] TOPO_INT_LOOP  = 2'h1;
   localparam logic [1:0] TOPO_DIFF_ALRT = 2'h2;
   localparam logic [1:0] TOPO_DUAL      = 2'h3;

   // register indices on the plain port
   localparam logic [3:0] ADDR_STATUS   = 4'h0;
   localparam logic [3:0] ADDR_ENABLE   = 4'h1;
   localparam logic [3:0] ADDR_CTRL     = 4'h2;
   localparam logic [3:0] ADDR_PACKET   = 4'h3;
   localparam logic [3:0] ADDR_TOPCELL  = 4'h4;
   localparam logic [3:0] ADDR_DIAG_B   = 4'h5;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
   localparam logic [3:0] ADDR_DIAG_A   = 4'h8;

   // primary status bit positions
   localparam int BIT_SCAN     = 15;
   localparam int BIT_POR      = 14;
   localparam int BIT_MISMATCH = 13;
   localparam int BIT_DIAG_A   = 1;
   localparam int BIT_DIAG_B   = 0;

   // control register fields
   localparam int CTRL_TOPO_LSB  = 0;
   localparam int CTRL_HW_EN     = 2;
   localparam int CTRL_IDLE_HIZ  = 3;
   localparam int CTRL_DC_TEST   = 4;

   // diagnostic register positions
   localparam int DIAG_B_USER    = 0;
   localparam int DIAG_A_LV_UV   = 0;
   localparam int DIAG_A_HV_UV   = 1;
   localparam int DIAG_A_BALSW   = 2;

   // values after reset
   localparam logic [15:0] STATUS_RST = 16'h4000;
   localparam logic [15:0] ENABLE_RST = 16'h0000;
   localparam logic [4:0]  CTRL_RST   = 5'h00;
   localparam logic [3:0]  TOPCELL_RST = 4'hD;

   // timing
   localparam int CLK_MHZ        = 125;
   localparam int SQ_HALF_NS     = 250;
   localparam int SQ_HALF_CYC    = SQ_HALF_NS * CLK_MHZ / 1000;
   localparam int DET_TIME_NS    = 25000;
   localparam int DET_CYC        = (DET_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int HALF_TOL_CYC   = 6;
   localparam logic [5:0] HALF_MIN = 6'(SQ_HALF_CYC - HALF_TOL_CYC);
   localparam logic [5:0] HALF_MAX = 6'(SQ_HALF_CYC + HALF_TOL_CYC);

   // interrupt status bits
   localparam int IRQ_ALERT  = 0;
   localparam int IRQ_UPLINK = 1;

endpackage : aas_pkg

// ===== rtl/aas_alert_top.sv
// alert aggregation, masking, packet word and alert pin signalling
// Operation
// - two-bit topology select chooses loopback, differential alert or dual mode
// - disabled interface sends nothing outside DC test mode and alert input is ignored
// - no alert outside DC test: output high-Z when idle-high-Z set, else driven low
// - differential topology without test mode keeps output at idle level
// - unmasked fault drives 2 MHz square wave at 50% duty
// - output lasts as long as fault, refreshed at scan rate
// - uplink alert recognised only after 25 us at expected frequency
// - enables mask the hardware alert but never the raw flags
// - hardware alert is OR of enabled flags except bit 6, plus power-on flag
// - power-on flag has no enable and always contributes
// - packet word bits 15 and 6 zero, bit 14 power-on flag
// - packet bits 13..7 carry masked mismatch and over/under flags
// - packet bits 5..0 carry masked PEC through diagnostic summaries
// - scan-done flag excluded from packet but usable in hardware alert
// - top-cell values mask balance-switch alerts unless they differ
// - low-supply undervoltage flag held off until power-on flag cleared
// - HV undervoltage flag suppressed until first power-on clear
// - user alert bit forces diagnostic summary b, making the alert active when bit 0 is enabled
module aas_alert_top
   import aas_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   // raw fault events from measurement and diagnostics
   input  wire logic [15:0] fault_evt_i,
   input  wire logic        lv_supply_uv_i,
   input  wire logic        hv_uv_i,
   input  wire logic        balance_switch_diag_i,
   input  wire logic        scan_tick_i,
   // register port
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   // alert pins
   input  wire logic        alert_in_pin_i,
   output logic             alert_out_pin_o,
   output logic             alert_out_pin_oe_o,
   // status outputs
   output logic      [15:0] packet_status_word_o,
   output logic             uplink_alert_o,
   output logic             irq_o
);

   logic [1:0]  rst_sync_q;
   logic        rst_n;
   logic [15:0] status_q;
   logic [15:0] enable_q;
   logic [4:0]  ctrl_q;
   logic [3:0]  top_a_q;
   logic [3:0]  top_b_q;
   logic        user_q;
   logic [2:0]  diag_a_q;
   logic        por_cleared_q;
   logic [1:0]  irq_stat_q;
   logic [1:0]  irq_mask_q;
   logic [1:0]  in_sync_q;
   logic        in_prev_q;
   logic [5:0]  half_cnt_q;
   logic [12:0] good_cnt_q;
   logic        uplink_q;
   logic [5:0]  sq_cnt_q;
   logic        sq_q;
   logic        alert_lat_q;
   logic        out_q;
   logic        oe_q;
   logic [15:0] pkt_q;
   logic        irq_q;

   logic [15:0] masked;
   logic [15:0] pkt_d;
   logic        active_d;
   logic [1:0]  topo;
   logic        hw_en;
   logic        idle_hiz;
   logic        dc_test;
   logic        balsw_masked;
   logic        por_clr_wr;
   logic        in_edge;
   logic [1:0]  irq_set;

   typedef enum logic [1:0]
   {
      OUT_IDLE  = 2'b00,
      OUT_WAVE  = 2'b01,
      OUT_LOW   = 2'b10,
      OUT_HIGH  = 2'b11
   } aas_out_t;
   aas_out_t out_mode;

   function automatic logic is_wr(input logic [3:0] a);
      is_wr = reg_wr_i && (reg_addr_i == a);
   endfunction : is_wr

   // reset release through two flops
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   assign topo     = ctrl_q[CTRL_TOPO_LSB +: 2];
   assign hw_en    = ctrl_q[CTRL_HW_EN];
   assign idle_hiz = ctrl_q[CTRL_IDLE_HIZ];
   assign dc_test  = ctrl_q[CTRL_DC_TEST];
   assign por_clr_wr = is_wr(ADDR_STATUS) && reg_wdata_i[BIT_POR];

   // balance-switch diag only reported when the two top cells differ
   assign balsw_masked = (top_a_q == top_b_q);

   // diagnostic register a: gated supply flags and balance-switch
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         diag_a_q      <= 3'h0;
         por_cleared_q <= 1'b0;
      end
      else
      begin
         if (por_clr_wr)
            por_cleared_q <= 1'b1;
         if (is_wr(ADDR_DIAG_A))
            diag_a_q <= diag_a_q & ~reg_wdata_i[2:0];
         // sets after the clear so a late event still lands
         if (lv_supply_uv_i && !status_q[BIT_POR])
            diag_a_q[DIAG_A_LV_UV] <= 1'b1;
         if (hv_uv_i && por_cleared_q)
            diag_a_q[DIAG_A_HV_UV] <= 1'b1;
         if (balance_switch_diag_i && !balsw_masked)
            diag_a_q[DIAG_A_BALSW] <= 1'b1;
      end
   end

   // raw status: sticky, write one to clear, set wins, bit 1 follows diag a; never masked
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         status_q <= STATUS_RST;
      else
      begin
         status_q <= (status_q & ~(is_wr(ADDR_STATUS) ? reg_wdata_i : 16'h0))
                     | fault_evt_i;
         status_q[BIT_DIAG_A] <= (|diag_a_q) || fault_evt_i[BIT_DIAG_A];
         // user bit forces the summary, keeping the path testable
         status_q[BIT_DIAG_B] <= user_q || fault_evt_i[BIT_DIAG_B] ||
            (status_q[BIT_DIAG_B] &&
             !(is_wr(ADDR_STATUS) && reg_wdata_i[BIT_DIAG_B]));
      end
   end

   // configuration registers
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_q   <= ENABLE_RST;
         ctrl_q     <= CTRL_RST;
         top_a_q    <= TOPCELL_RST;
         top_b_q    <= TOPCELL_RST;
         user_q     <= 1'b0;
         irq_mask_q <= 2'h0;
      end
      else
      begin
         if (is_wr(ADDR_ENABLE))
            enable_q <= reg_wdata_i;
         if (is_wr(ADDR_CTRL))
            ctrl_q <= reg_wdata_i[4:0];
         if (is_wr(ADDR_TOPCELL))
         begin
            top_a_q <= reg_wdata_i[3:0];
            top_b_q <= reg_wdata_i[11:8];
         end
         if (is_wr(ADDR_DIAG_B))
            user_q <= reg_wdata_i[DIAG_B_USER];
         if (is_wr(ADDR_IRQ_MASK))
            irq_mask_q <= reg_wdata_i[1:0];
      end
   end

   // masking; power-on bit has no enable
   always_comb
   begin
      masked = status_q & enable_q;
      masked[BIT_POR] = status_q[BIT_POR];
      // bit 6 is no alert source, keep it out of the aggregate
      masked[6] = 1'b0;
      active_d = |masked;
      pkt_d = masked;
      pkt_d[15] = 1'b0;
      pkt_d[6]  = 1'b0;
      pkt_d[BIT_POR] = status_q[BIT_POR];
      // bits 13..7 and 5..0 follow the status layout directly
      pkt_d[13:7] = status_q[13:7] & enable_q[13:7];
      pkt_d[5:0]  = status_q[5:0] & enable_q[5:0];
   end

   // alert latch refreshed only at scan ticks
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alert_lat_q <= 1'b0;
         pkt_q       <= 16'h0000;
      end
      else
      begin
         pkt_q <= pkt_d;
         if (scan_tick_i)
            alert_lat_q <= active_d;
      end
   end

   // 2 MHz square wave generator
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sq_cnt_q <= 6'h00;
         sq_q     <= 1'b0;
      end
      else if (!alert_lat_q)
      begin
         sq_cnt_q <= 6'h00;
         sq_q     <= 1'b1;
      end
      else if (sq_cnt_q == 6'(SQ_HALF_CYC - 1))
      begin
         sq_cnt_q <= 6'h00;
         sq_q     <= ~sq_q;
      end
      else
         sq_cnt_q <= sq_cnt_q + 6'h01;
   end

   // output driver selection
   always_comb
   begin
      if (dc_test)
         out_mode = alert_lat_q ? OUT_LOW : OUT_HIGH;
      else if (!hw_en || !alert_lat_q)
         out_mode = OUT_IDLE;
      else if (topo == TOPO_DIFF_ALRT)
         out_mode = OUT_IDLE;
      else
         out_mode = OUT_WAVE;
   end

   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_q <= 1'b0;
         oe_q  <= 1'b0;
      end
      else
      begin
         case (out_mode)
            OUT_IDLE:
            begin
               out_q <= 1'b0;
               oe_q  <= ~idle_hiz;
            end
            OUT_WAVE:
            begin
               out_q <= sq_q;
               oe_q  <= 1'b1;
            end
            OUT_LOW:
            begin
               out_q <= 1'b0;
               oe_q  <= 1'b1;
            end
            OUT_HIGH:
            begin
               out_q <= 1'b1;
               oe_q  <= 1'b1;
            end
            default:
            begin
               out_q <= 1'b0;
               oe_q  <= 1'b0;
            end
         endcase
      end
   end

   // uplink detector; pin input synchronised first
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_sync_q <= 2'h0;
         in_prev_q <= 1'b0;
      end
      else
      begin
         in_sync_q <= {in_sync_q[0], alert_in_pin_i};
         in_prev_q <= in_sync_q[1];
      end
   end
   assign in_edge = in_sync_q[1] ^ in_prev_q;

   // every half period must fall in tolerance; any miss restarts
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         half_cnt_q <= 6'h00;
         good_cnt_q <= 13'h0000;
         uplink_q   <= 1'b0;
      end
      else if (!hw_en || topo == TOPO_DIFF_ALRT)
      begin
         half_cnt_q <= 6'h00;
         good_cnt_q <= 13'h0000;
         uplink_q   <= 1'b0;
      end
      else if (in_edge)
      begin
         half_cnt_q <= 6'h00;
         if (half_cnt_q >= HALF_MIN && half_cnt_q <= HALF_MAX)
         begin
            if (good_cnt_q >= 13'(DET_CYC - 1))
               uplink_q <= 1'b1;
            else
               good_cnt_q <= good_cnt_q + 13'(half_cnt_q) + 13'h0001;
         end
         else
         begin
            good_cnt_q <= 13'h0000;
            uplink_q   <= 1'b0;
         end
      end
      else if (half_cnt_q > HALF_MAX)
      begin
         good_cnt_q <= 13'h0000;
         uplink_q   <= 1'b0;
      end
      else
         half_cnt_q <= half_cnt_q + 6'h01;
   end

   // interrupt status: set wins over write-one clear
   assign irq_set = {uplink_q, active_d};
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_stat_q <= 2'h0;
         irq_q      <= 1'b0;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q &
            ~(is_wr(ADDR_IRQ_STAT) ? reg_wdata_i[1:0] : 2'h0)) | irq_set;
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   // read port, data one cycle after strobe
   always_ff @(posedge ref_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_o <= 16'h0000;
      else if (reg_rd_i)
      begin
         case (reg_addr_i)
            ADDR_STATUS:   reg_rdata_o <= status_q;
            ADDR_ENABLE:   reg_rdata_o <= enable_q;
            ADDR_CTRL:     reg_rdata_o <= {11'h000, ctrl_q};
            ADDR_PACKET:   reg_rdata_o <= pkt_q;
            ADDR_TOPCELL:  reg_rdata_o <= {4'h0, top_b_q, 4'h0, top_a_q};
            ADDR_DIAG_B:   reg_rdata_o <= {15'h0000, user_q};
            ADDR_IRQ_STAT: reg_rdata_o <= {14'h0000, irq_stat_q};
            ADDR_IRQ_MASK: reg_rdata_o <= {14'h0000, irq_mask_q};
            ADDR_DIAG_A:   reg_rdata_o <= {13'h0000, diag_a_q};
            default:       reg_rdata_o <= 16'h0000;
         endcase
      end
      else
         reg_rdata_o <= 16'h0000;
   end

   assign alert_out_pin_o      = out_q;
   assign alert_out_pin_oe_o   = oe_q;
   assign packet_status_word_o = pkt_q;
   assign uplink_alert_o       = uplink_q;
   assign irq_o                = irq_q;

endmodule : aas_alert_top

// ===== tb/aas_alert_props.sv
// port checker for the alert block
module aas_alert_props
   import aas_pkg::*;
(
   // clock and reset
   input wire logic        ref_clk_i,
   input wire logic        arst_n_i,
   // register port
   input wire logic [3:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   // pins and status
   input wire logic        alert_in_pin_i,
   input wire logic        alert_out_pin_o,
   input wire logic        alert_out_pin_oe_o,
   input wire logic [15:0] packet_status_word_o,
   input wire logic        uplink_alert_o,
   input wire logic        irq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   localparam int HALF_GAP = SQ_HALF_CYC - 1;
   localparam int RUN_MIN  = DET_CYC - 62;
   logic        out_q;
   logic        in_q;
   logic [11:0] gap_q;
   logic [11:0] run_q;
   logic [6:0]  quiet_q;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   // counters saturate so a long idle span never wraps into a short gap
   always_ff @(posedge ref_clk_i or negedge arst_n_i)
      if (!arst_n_i)
         {out_q, in_q, gap_q, run_q, quiet_q} <= '0;
      else
      begin
         out_q <= alert_out_pin_o;
         in_q  <= alert_in_pin_i;
         if (alert_out_pin_o != out_q)
            gap_q <= 12'h000;
         else if (gap_q != 12'hFFF)
            gap_q <= gap_q + 12'h001;
         if (alert_in_pin_i != in_q)
            quiet_q <= 7'h00;
         else if (quiet_q != 7'h7F)
            quiet_q <= quiet_q + 7'h01;
         if (quiet_q >= 7'h28)
            run_q <= 12'h000;
         else if (run_q != 12'hFFF)
            run_q <= run_q + 12'h001;
      end

   chk_rd_idle:
      assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
      else $error("read data outside answer cycle");
   chk_unmap_zero:
      assert property (reg_rd_i && reg_addr_i > ADDR_DIAG_A |=> !reg_rdata_o)
      else $error("unmapped read not zero");
   chk_enable_echo:
      assert property ((reg_wr_i && reg_addr_i == ADDR_ENABLE) ##1
         (reg_rd_i && reg_addr_i == ADDR_ENABLE)
         |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("enable readback differs");
   chk_pkt_fixed:
      assert property (!packet_status_word_o[15] && !packet_status_word_o[6])
      else $error("packet fixed bits not zero");
   chk_oe_low:
      assert property (!alert_out_pin_oe_o |-> !alert_out_pin_o)
      else $error("undriven alert output not low");
   // a short half may only be the stop of the wave toward idle
   chk_wave_half:
      assert property (alert_out_pin_oe_o && $past(alert_out_pin_oe_o) &&
         alert_out_pin_o != out_q && gap_q < HALF_GAP |-> !alert_out_pin_o)
      else $error("alert wave half period too short");
   chk_uplink_min:
      assert property ($rose(uplink_alert_o) |-> run_q >= RUN_MIN)
      else $error("uplink alert before detect time");
   chk_uplink_drop:
      assert property (quiet_q >= 7'd48 |-> !uplink_alert_o)
      else $error("uplink alert without input edges");

   cov_wave: cover property (alert_out_pin_oe_o && alert_out_pin_o != out_q
      && gap_q == 12'(HALF_GAP));
   cov_up: cover property ($rose(uplink_alert_o));
   cov_irq: cover property ($rose(irq_o));
endmodule : aas_alert_props

bind aas_alert_top aas_alert_props i_aas_alert_props (
   .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .alert_in_pin_i(alert_in_pin_i),
   .alert_out_pin_o(alert_out_pin_o),
   .alert_out_pin_oe_o(alert_out_pin_oe_o),
   .packet_status_word_o(packet_status_word_o),
   .uplink_alert_o(uplink_alert_o), .irq_o(irq_o)
);

// ===== tb/aas_neighbour_model.sv
// neighbouring device driving its alert output into the block
module aas_neighbour_model
(
   // control from the bench
   input  wire logic        run_i,
   input  wire logic [15:0] half_ns_i,
   // alert line toward the block
   output logic             pin_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // idles driven low, as a neighbour with a low idle level does
   initial
   begin
      pin_o = 1'b0;
      forever
      begin
         wait (run_i);
         while (run_i)
            #(half_ns_i) pin_o = ~pin_o;
         pin_o = 1'b0;
      end
   end
endmodule : aas_neighbour_model

// ===== tb/alert_aggregation_signaling_tb.sv
// bench for the alert aggregation and signalling block
module alert_aggregation_signaling_tb
   import aas_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, rst_n, wr, rd, tick, lv, hv, bal, run;
   logic        ain, aout, aoe, up, irq;
   logic [3:0]  addr;
   logic [15:0] wdata, evt, rdata, pkt, half_ns;
   int          n_mismatch, tests_run, n;

   aas_alert_top i_aas_alert_top (
      .ref_clk_i(clk), .arst_n_i(rst_n), .fault_evt_i(evt),
      .lv_supply_uv_i(lv), .hv_uv_i(hv), .balance_switch_diag_i(bal),
      .scan_tick_i(tick), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .alert_in_pin_i(ain), .alert_out_pin_o(aout),
      .alert_out_pin_oe_o(aoe), .packet_status_word_o(pkt),
      .uplink_alert_o(up), .irq_o(irq)
   );
   aas_neighbour_model i_aas_neighbour_model (
      .run_i(run), .half_ns_i(half_ns), .pin_o(ain)
   );

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : cyc

   task automatic chk(input string nm, input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk

   task automatic op(input logic w, r, input logic [3:0] a,
                     input logic [15:0] d);
      @(posedge clk);
      wr    <= w;
      rd    <= r;
      addr  <= a;
      wdata <= d;
   endtask : op

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      op(1'b1, 1'b0, a, d);
      op(1'b0, 1'b0, a, d);
   endtask : wr_reg

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input string nm, input logic [3:0] a,
                         input logic [15:0] e);
      op(1'b0, 1'b1, a, 16'h0000);
      op(1'b0, 1'b0, a, 16'h0000);
      #1;
      chk(nm, rdata, e);
   endtask : rd_chk

   task automatic pulse(input logic [15:0] e, input logic t);
      @(posedge clk);
      evt  <= e;
      tick <= t;
      @(posedge clk);
      evt  <= 16'h0000;
      tick <= 1'b0;
   endtask : pulse

   // cycles between two changes of the alert output
   task automatic half(output int m);
      logic v;
      int   k;
      k = 0;
      m = 0;
      v = aout;
      while (aout === v && k < 100)
      begin
         cyc(1);
         k++;
      end
      v = aout;
      while (aout === v && m < 100)
      begin
         cyc(1);
         m++;
      end
   endtask : half

   // neighbour runs a while; the uplink flag must never rise
   task automatic burst(input logic [15:0] c, hn, input int len);
      int hi;
      hi = 0;
      wr_reg(ADDR_CTRL, c);
      @(posedge clk);
      half_ns <= hn;
      run     <= 1'b1;
      repeat (len)
      begin
         cyc(1);
         hi += (up !== 1'b0);
      end
      @(posedge clk);
      run <= 1'b0;
      // neighbour may finish one more half before it stops
      cyc(90);
      chk("up_cycles", 16'(hi), 16'h0000);
   endtask : burst

   task automatic t_power;
      rd_chk("status", ADDR_STATUS, STATUS_RST);
      chk("packet", pkt, 16'h4000);
      @(posedge clk);
      {lv, hv, bal} <= 3'b111;
      cyc(4);
      rd_chk("diag_a", ADDR_DIAG_A, 16'h0000);
      wr_reg(ADDR_STATUS, 16'h4000);
      cyc(4);
      rd_chk("diag_a", ADDR_DIAG_A, 16'h0003);
      wr_reg(ADDR_TOPCELL, 16'h0D05);
      cyc(4);
      rd_chk("diag_a", ADDR_DIAG_A, 16'h0007);
      @(posedge clk);
      {lv, hv, bal} <= 3'b000;
      wr_reg(ADDR_DIAG_A, 16'h0007);
      rd_chk("diag_a", ADDR_DIAG_A, 16'h0000);
      $display("power done");
   endtask : t_power

   task automatic t_packet;
      int i;
      pulse(16'hFFFC, 1'b0);
      op(1'b1, 1'b0, ADDR_ENABLE, 16'hFFFF);
      rd_chk("enable", ADDR_ENABLE, 16'hFFFF);
      chk("packet", pkt, 16'h7FBC);
      for (i = 0; i < 16; i++)
      begin
         wr_reg(ADDR_ENABLE, 16'h0001 << i);
         cyc(2);
         chk("packet", pkt, 16'h0001 << i & 16'h3FBC | 16'h4000);
      end
      wr_reg(ADDR_ENABLE, 16'h0000);
      rd_chk("status", ADDR_STATUS, 16'hFFFC);
      wr_reg(ADDR_STATUS, 16'hFFFF);
      rd_chk("status", ADDR_STATUS, 16'h0000);
      $display("packet done");
   endtask : t_packet

   task automatic t_wave;
      int i;
      wr_reg(ADDR_CTRL, 16'h000C);
      wr_reg(ADDR_ENABLE, 16'h0040);
      pulse(16'h0040, 1'b0);
      pulse(16'h0000, 1'b1);
      cyc(3);
      chk("oe", 16'(aoe), 16'h0000);
      chk("pin", 16'({aoe, aout}), 16'h0000);
      wr_reg(ADDR_ENABLE, 16'h8000);
      pulse(16'h8000, 1'b0);
      pulse(16'h0000, 1'b1);
      for (i = 0; i < 4; i++)
         if (i != 2)
         begin
            wr_reg(ADDR_CTRL, 16'h000C | 16'(i));
            half(n);
            chk("half", 16'(n), 16'(SQ_HALF_CYC));
         end
      wr_reg(ADDR_CTRL, 16'h000E);
      cyc(3);
      chk("oe", 16'(aoe), 16'h0000);
      wr_reg(ADDR_CTRL, 16'h0006);
      repeat (3)
      begin
         cyc(20);
         chk("pin", 16'({aoe, aout}), 16'h0002);
      end
      wr_reg(ADDR_CTRL, 16'h0016);
      cyc(3);
      chk("pin", 16'({aoe, aout}), 16'h0002);
      wr_reg(ADDR_STATUS, 16'h8000);
      cyc(3);
      chk("pin", 16'({aoe, aout}), 16'h0002);
      pulse(16'h0000, 1'b1);
      cyc(3);
      chk("pin", 16'({aoe, aout}), 16'h0003);
      $display("wave done");
   endtask : t_wave

   task automatic t_uplink;
      int k;
      k = 0;
      wr_reg(ADDR_IRQ_STAT, 16'h0003);
      wr_reg(ADDR_CTRL, 16'h0004);
      @(posedge clk);
      half_ns <= 16'd250;
      run     <= 1'b1;
      while (up !== 1'b1 && k < 5000)
      begin
         cyc(1);
         k++;
      end
      chk("detect", 16'(k >= DET_CYC && k < DET_CYC + 120), 16'h0001);
      chk("irq", 16'(irq), 16'h0000);
      wr_reg(ADDR_IRQ_MASK, 16'h0002);
      cyc(2);
      chk("irq", 16'(irq), 16'h0001);
      @(posedge clk);
      run <= 1'b0;
      cyc(90);
      chk("up", 16'(up), 16'h0000);
      rd_chk("irq_stat", ADDR_IRQ_STAT, 16'h0002);
      wr_reg(ADDR_IRQ_STAT, 16'h0002);
      cyc(2);
      chk("irq", 16'(irq), 16'h0000);
      burst(16'h0004, 16'd250, 1000);
      burst(16'h0004, 16'd400, 3500);
      burst(16'h0000, 16'd250, 3500);
      burst(16'h0006, 16'd250, 3500);
      $display("uplink done");
   endtask : t_uplink

   task automatic t_user;
      wr_reg(ADDR_ENABLE, 16'h0001);
      wr_reg(ADDR_DIAG_B, 16'h0001);
      cyc(2);
      chk("packet", pkt, 16'h0001);
      wr_reg(ADDR_CTRL, 16'h000C);
      pulse(16'h0000, 1'b1);
      half(n);
      chk("half", 16'(n), 16'(SQ_HALF_CYC));
      rd_chk("unmapped", 4'h9, 16'h0000);
      $display("user done");
   endtask : t_user

   task automatic conclude;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   initial
   begin
      {rst_n, wr, rd, tick, lv, hv, bal, run} = '0;
      {addr, wdata, evt} = '0;
      half_ns = 16'd250;
      n_mismatch = 0;
      tests_run = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      cyc(3);
      t_power();
      t_packet();
      t_wave();
      t_uplink();
      t_user();
      conclude();
   end

   // the whole run needs about 16000 cycles
   initial
   begin
      #320000;
      n_mismatch++;
      conclude();
   end
endmodule : alert_aggregation_signaling_tb
